// ==== logic/egress_consts.vh ====
// Constants for the egress rate limiter and tag editor.
`ifndef EGRESS_CONSTS_VH
`define EGRESS_CONSTS_VH
// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define OFF_PORT_TYPE 8'h00
`define OFF_LIMIT_EN 8'h04
`define OFF_ELIGIBLE 8'h08
`define OFF_DFLT_BASE 8'h10
`define OFF_RATE_BASE 8'h20
`define OFF_TDROP_BASE 8'h50
`define OFF_RDROP_BASE 8'h60
// ----------------------------------------------------------------
// Field layouts and reset values
// ----------------------------------------------------------------
`define PT_TYPE_LSB 0
`define PT_INSERT_BIT 2
`define PT_CHG_TAG_BIT 3
`define PT_CHG_VID_BIT 4
`define PT_CHG_PRIO_BIT 5
`define PT_WR_MASK 32'h003f3f3f
`define DFLT_PRIO_LSB 12
`define DFLT_WR_MASK 32'h00007fff
`define RATE_W 13
`define LEN_W 11
`define HOLD_W 25
`define RST_PORT_TYPE 32'h00000000
`define RST_DFLT 15'h0001
`define RST_RATE 13'h0000
// ----------------------------------------------------------------
// Encodings
// ----------------------------------------------------------------
`define PORT_DUMB 2'h0
`define PORT_ACCESS 2'h1
`define PORT_HYBRID 2'h2
`define PORT_CPU 2'h3
`define PKT_UNTAGGED 2'h0
`define PKT_PRIO_TAG 2'h1
`define PKT_NORMAL_TAG 2'h2
`define PKT_SPECIAL_TAG 2'h3
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define HOLD_STEP_NS 20
`define CLK_PERIOD_NS 40
`define STEPS_PER_CYCLE (`CLK_PERIOD_NS / `HOLD_STEP_NS)
`define MIN_RATE_MULT 14'h0004
`define SLOW_PORT_MAX_RATE 13'h0027
`endif

// ==== logic/queue_limiter.v ====
// Leaky-bucket hold-off timer for one transmit priority queue.
`timescale 1ns/1ps
`include "egress_consts.vh"
module queue_limiter (
  input wire aclk,
  input wire aresetn,
  input wire ce,
  input wire enable,
  input wire bypass,
  input wire [`RATE_W-1:0] rate_setting,
  input wire start,
  input wire [`LEN_W-1:0] pkt_len,
  output wire blocked
);
  reg [`HOLD_W-1:0] hold_r;
  reg [`HOLD_W-1:0] hold_nxt;
  wire [13:0] mult;
  wire [`HOLD_W-1:0] load;
  localparam integer STEP_I = `STEPS_PER_CYCLE;
  localparam [`HOLD_W-1:0] STEP = STEP_I[`HOLD_W-1:0];

  // Hold counts in 20 ns units; low settings clamp to 80 ns per byte.
  assign mult = (rate_setting < 13'h0004) ? `MIN_RATE_MULT :
                ({1'b0, rate_setting} + 14'h0001);
  assign load = pkt_len * mult;
  assign blocked = (hold_r != {`HOLD_W{1'b0}});

  always @* begin
    hold_nxt = hold_r;
    if (start && enable && !bypass) begin
      hold_nxt = load;
    end else if (hold_r >= STEP) begin
      hold_nxt = hold_r - STEP;
    end else begin
      hold_nxt = {`HOLD_W{1'b0}};
    end
    if (!enable || bypass) begin
      hold_nxt = {`HOLD_W{1'b0}};
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      hold_r <= {`HOLD_W{1'b0}};
    end else if (ce) begin
      hold_r <= hold_nxt;
    end
  end
endmodule // queue_limiter

// ==== logic/egress_shaper_tagger.v ====
// Egress rate limiting, VLAN tag editing and drop counters per port.
//
// The register addresses and the AXI4-Lite slave port were decided locally.
`timescale 1ns/1ps
`include "egress_consts.vh"
module egress_shaper_tagger (
  input wire aclk,
  input wire aresetn,
  input wire ce,
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire [11:0] q_nonempty,
  input wire [2:0] port_10m,
  output reg [11:0] q_eligible,
  input wire sel_valid,
  input wire [1:0] sel_port,
  input wire [1:0] sel_queue,
  input wire [`LEN_W-1:0] sel_len,
  input wire tag_req,
  input wire [1:0] tag_pkt_type,
  input wire [1:0] tag_ingress_port,
  input wire [1:0] tag_egress_port,
  input wire [11:0] tag_rx_vid,
  input wire [2:0] tag_rx_prio,
  input wire [2:0] tag_untag_bits,
  output reg tag_done,
  output reg tag_strip_vlan,
  output reg tag_strip_special,
  output reg tag_insert_vlan,
  output reg tag_rewrite_vlan,
  output reg [11:0] tag_out_vid,
  output reg [2:0] tag_out_prio,
  output reg tag_add_special,
  output reg [11:0] tag_special_vid,
  output reg fcs_recompute,
  input wire drop_valid,
  input wire [1:0] drop_src_port,
  input wire drop_by_rate
);
  // ----------------------------------------------------------------
  // Configuration and counter state
  // ----------------------------------------------------------------
  reg [31:0] egress_port_type_cfg;
  reg [11:0] limit_en_r;
  reg [14:0] dflt_r [0:2];
  reg [`RATE_W-1:0] rate_r [0:11];
  reg [31:0] total_drop_r [0:2];
  reg [31:0] rate_drop_r [0:2];
  wire [11:0] blocked;
  wire [11:0] start;
  wire [3:0] sel_idx;
  wire [14:0] port0_default_vid_prio;
  wire [14:0] port1_default_vid_prio;
  wire [14:0] port2_default_vid_prio;
  wire [31:0] port0_total_drop_count;
  wire [31:0] port1_total_drop_count;
  wire [31:0] port2_total_drop_count;
  wire [31:0] port0_rate_drop_count;
  wire [31:0] port1_rate_drop_count;
  wire [31:0] port2_rate_drop_count;
  integer i;
  integer k;

  assign port0_default_vid_prio = dflt_r[0];
  assign port1_default_vid_prio = dflt_r[1];
  assign port2_default_vid_prio = dflt_r[2];
  assign port0_total_drop_count = total_drop_r[0];
  assign port1_total_drop_count = total_drop_r[1];
  assign port2_total_drop_count = total_drop_r[2];
  assign port0_rate_drop_count = rate_drop_r[0];
  assign port1_rate_drop_count = rate_drop_r[1];
  assign port2_rate_drop_count = rate_drop_r[2];

  // ----------------------------------------------------------------
  // Per-queue limiters
  // ----------------------------------------------------------------
  assign sel_idx = {sel_port, sel_queue};

  genvar g;
  generate
    for (g = 0; g < 12; g = g + 1) begin : lim
      assign start[g] = sel_valid && (sel_idx == g);
      queue_limiter u_lim (
        .aclk(aclk),
        .aresetn(aresetn),
        .ce(ce),
        .enable(limit_en_r[g]),
        .bypass(port_10m[g/4] && (rate_r[g] > `SLOW_PORT_MAX_RATE)),
        .rate_setting(rate_r[g]),
        .start(start[g]),
        .pkt_len(sel_len),
        .blocked(blocked[g])
      );
    end
  endgenerate

  // A queue that was just picked is masked at once, so the scheduler
  // cannot pick it twice before its counter loads. Held packets simply
  // stay in the shared buffer; overflow drops are made upstream.
  always @(posedge aclk) begin
    if (!aresetn) begin
      q_eligible <= 12'h000;
    end else if (ce) begin
      q_eligible <= q_nonempty & ~(blocked | start);
    end
  end

  // ----------------------------------------------------------------
  // Tag editor
  // ----------------------------------------------------------------
  // Defaults come in as arguments, so the editor reacts to every write.
  function [14:0] dflt_of;
    input [1:0] p;
    input [14:0] d0;
    input [14:0] d1;
    input [14:0] d2;
    begin
      case (p)
        2'h0: dflt_of = d0;
        2'h1: dflt_of = d1;
        2'h2: dflt_of = d2;
        default: dflt_of = 15'h0000;
      endcase
    end
  endfunction

  reg [7:0] ecfg;
  reg [14:0] in_dflt;
  reg [14:0] eg_dflt;
  reg untag;
  reg strip_v;
  reg strip_s;
  reg ins_v;
  reg rew_v;
  reg add_s;
  reg [11:0] new_vid;
  reg [2:0] new_prio;

  always @* begin
    ecfg = egress_port_type_cfg[{tag_egress_port, 3'b000} +: 8];
    in_dflt = dflt_of(tag_ingress_port, port0_default_vid_prio,
      port1_default_vid_prio, port2_default_vid_prio);
    eg_dflt = dflt_of(tag_egress_port, port0_default_vid_prio,
      port1_default_vid_prio, port2_default_vid_prio);
    untag = tag_untag_bits[tag_ingress_port];
    strip_v = 1'b0;
    strip_s = 1'b0;
    ins_v = 1'b0;
    rew_v = 1'b0;
    add_s = 1'b0;
    new_vid = tag_rx_vid;
    new_prio = tag_rx_prio;
    case (ecfg[`PT_TYPE_LSB +: 2])
      `PORT_DUMB: begin
        strip_s = (tag_pkt_type == `PKT_SPECIAL_TAG);
      end
      `PORT_ACCESS: begin
        strip_s = (tag_pkt_type == `PKT_SPECIAL_TAG);
        strip_v = (tag_pkt_type == `PKT_PRIO_TAG) ||
                  (tag_pkt_type == `PKT_NORMAL_TAG);
      end
      `PORT_HYBRID: begin
        case (tag_pkt_type)
          `PKT_UNTAGGED: begin
            ins_v = ecfg[`PT_INSERT_BIT] && !untag;
            new_vid = in_dflt[11:0];
            new_prio = in_dflt[`DFLT_PRIO_LSB +: 3];
          end
          `PKT_PRIO_TAG: begin
            strip_v = untag;
            rew_v = !untag;
            new_vid = in_dflt[11:0];
            if (ecfg[`PT_CHG_PRIO_BIT]) begin
              new_prio = in_dflt[`DFLT_PRIO_LSB +: 3];
            end
          end
          `PKT_NORMAL_TAG: begin
            strip_v = untag;
            rew_v = !untag && ecfg[`PT_CHG_TAG_BIT] &&
                    (ecfg[`PT_CHG_VID_BIT] ||
                     ecfg[`PT_CHG_PRIO_BIT]);
            if (ecfg[`PT_CHG_VID_BIT]) begin
              new_vid = eg_dflt[11:0];
            end
            if (ecfg[`PT_CHG_PRIO_BIT]) begin
              new_prio = eg_dflt[`DFLT_PRIO_LSB +: 3];
            end
          end
          default: begin
            strip_s = 1'b1;
          end
        endcase
      end
      default: begin
        // A special tag from the CPU is replaced, never stacked twice.
        add_s = 1'b1;
        strip_s = (tag_pkt_type == `PKT_SPECIAL_TAG);
      end
    endcase
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      tag_done <= 1'b0;
      tag_strip_vlan <= 1'b0;
      tag_strip_special <= 1'b0;
      tag_insert_vlan <= 1'b0;
      tag_rewrite_vlan <= 1'b0;
      tag_out_vid <= 12'h000;
      tag_out_prio <= 3'h0;
      tag_add_special <= 1'b0;
      tag_special_vid <= 12'h000;
      fcs_recompute <= 1'b0;
    end else if (ce) begin
      tag_done <= tag_req;
      if (tag_req) begin
        tag_strip_vlan <= strip_v;
        tag_strip_special <= strip_s;
        tag_insert_vlan <= ins_v;
        tag_rewrite_vlan <= rew_v;
        tag_out_vid <= new_vid;
        tag_out_prio <= new_prio;
        tag_add_special <= add_s;
        tag_special_vid <= {10'h000, tag_ingress_port};
        fcs_recompute <= strip_v | strip_s | ins_v | rew_v | add_s;
      end
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite write path
  // ----------------------------------------------------------------
  reg [7:0] awaddr_r;
  reg [31:0] wdata_r;
  reg [3:0] wstrb_r;
  reg aw_held;
  reg w_held;
  wire do_write;
  wire [31:0] bmask;
  wire [5:0] widx;
  wire [31:0] dmask;

  assign do_write = aw_held && w_held && !s_axi_bvalid;
  assign dmask = bmask & `DFLT_WR_MASK;
  assign bmask = {{8{wstrb_r[3]}}, {8{wstrb_r[2]}},
                  {8{wstrb_r[1]}}, {8{wstrb_r[0]}}};
  assign widx = awaddr_r[7:2];

  function [31:0] merge;
    input [31:0] old;
    input [31:0] nw;
    input [31:0] m;
    begin
      merge = (old & ~m) | (nw & m);
    end
  endfunction

  function wmapped;
    input [5:0] x;
    begin
      wmapped = (x == 6'h00) || (x == 6'h01) ||
                (x >= 6'h04 && x <= 6'h06) ||
                (x >= 6'h08 && x <= 6'h13);
    end
  endfunction

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
      aw_held <= 1'b0;
      w_held <= 1'b0;
      awaddr_r <= 8'h00;
      wdata_r <= 32'h00000000;
      wstrb_r <= 4'h0;
      egress_port_type_cfg <= `RST_PORT_TYPE;
      limit_en_r <= 12'h000;
      for (i = 0; i < 3; i = i + 1) begin
        dflt_r[i] <= `RST_DFLT;
      end
      for (i = 0; i < 12; i = i + 1) begin
        rate_r[i] <= `RST_RATE;
      end
    end else if (ce) begin
      s_axi_awready <= !aw_held && !s_axi_awready;
      s_axi_wready <= !w_held && !s_axi_wready;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        awaddr_r <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (do_write) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wmapped(widx) ? `RESP_OKAY : `RESP_SLVERR;
        if (widx == 6'h00) begin
          egress_port_type_cfg <= merge(egress_port_type_cfg, wdata_r,
                                        bmask & `PT_WR_MASK);
        end
        if (widx == 6'h01) begin
          limit_en_r <= (limit_en_r & ~bmask[11:0]) |
                        (wdata_r[11:0] & bmask[11:0]);
        end
        for (i = 0; i < 3; i = i + 1) begin
          if (widx == 6'h04 + i) begin
            dflt_r[i] <= (dflt_r[i] & ~dmask[14:0]) |
                         (wdata_r[14:0] & dmask[14:0]);
          end
        end
        for (i = 0; i < 12; i = i + 1) begin
          if (widx == 6'h08 + i) begin
            rate_r[i] <= (rate_r[i] & ~bmask[12:0]) |
                         (wdata_r[12:0] & bmask[12:0]);
          end
        end
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite read path
  // ----------------------------------------------------------------
  reg [31:0] rd_mux;
  reg rd_ok;
  wire [5:0] ridx;

  assign ridx = s_axi_araddr[7:2];

  always @* begin
    rd_mux = 32'h00000000;
    rd_ok = 1'b1;
    case (ridx)
      6'h00: rd_mux = egress_port_type_cfg;
      6'h01: rd_mux = {20'h00000, limit_en_r};
      6'h02: rd_mux = {20'h00000, blocked};
      6'h04: rd_mux = {17'h00000, port0_default_vid_prio};
      6'h05: rd_mux = {17'h00000, port1_default_vid_prio};
      6'h06: rd_mux = {17'h00000, port2_default_vid_prio};
      6'h14: rd_mux = port0_total_drop_count;
      6'h15: rd_mux = port1_total_drop_count;
      6'h16: rd_mux = port2_total_drop_count;
      6'h18: rd_mux = port0_rate_drop_count;
      6'h19: rd_mux = port1_rate_drop_count;
      6'h1a: rd_mux = port2_rate_drop_count;
      default: begin
        if (ridx >= 6'h08 && ridx <= 6'h13) begin
          rd_mux = {19'h00000, rate_r[ridx[3:0] - 4'h8]};
        end else begin
          rd_ok = 1'b0;
        end
      end
    endcase
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `RESP_OKAY;
    end else if (ce) begin
      s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_mux;
        s_axi_rresp <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
      end
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Drop counters
  // ----------------------------------------------------------------
  // Counters wrap and are cleared only by reset, so software takes differences.
  always @(posedge aclk) begin
    if (!aresetn) begin
      for (k = 0; k < 3; k = k + 1) begin
        total_drop_r[k] <= 32'h00000000;
        rate_drop_r[k] <= 32'h00000000;
      end
    end else if (ce) begin
      for (k = 0; k < 3; k = k + 1) begin
        if (drop_valid && (drop_src_port == k)) begin
          total_drop_r[k] <= total_drop_r[k] + 32'h00000001;
          if (drop_by_rate) begin
            rate_drop_r[k] <= rate_drop_r[k] + 32'h00000001;
          end
        end
      end
    end
  end
endmodule // egress_shaper_tagger

// ==== dv/egress_shaper_tagger_checker.sv ====
// Port assertions for the egress shaper and tag editor.
`timescale 1ns/1ps
`include "egress_consts.vh"
module egress_shaper_tagger_checker (
  input wire aclk,
  input wire aresetn,
  input wire [11:0] q_nonempty,
  input wire [11:0] q_eligible,
  input wire sel_valid,
  input wire [1:0] sel_port,
  input wire [1:0] sel_queue,
  input wire tag_req,
  input wire [1:0] tag_pkt_type,
  input wire [1:0] tag_ingress_port,
  input wire tag_done,
  input wire tag_strip_vlan,
  input wire tag_strip_special,
  input wire tag_insert_vlan,
  input wire tag_rewrite_vlan,
  input wire tag_add_special,
  input wire [11:0] tag_special_vid,
  input wire fcs_recompute
);
  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  reg [3:0] idx_r;
  // The picked queue index is kept so its bit can be watched later.
  always @(posedge aclk) begin
    idx_r <= {sel_port, sel_queue};
  end
  property p_done; tag_done == $past(tag_req); endproperty
  a_done: assert property (p_done) else $error("tag done timing");
  property p_pick; sel_valid && sel_port != 2'h3 |=> !q_eligible[idx_r];
  endproperty
  a_pick: assert property (p_pick) else $error("picked queue open");
  property p_elig; (q_eligible & ~$past(q_nonempty)) == 12'h000;
  endproperty
  a_elig: assert property (p_elig) else $error("empty queue open");
  property p_svid;
    tag_done && tag_add_special |->
      tag_special_vid == {10'h000, $past(tag_ingress_port)};
  endproperty
  a_svid: assert property (p_svid) else $error("special vid");
  property p_ssp;
    tag_done && $past(tag_pkt_type) == `PKT_SPECIAL_TAG |-> tag_strip_special;
  endproperty
  a_ssp: assert property (p_ssp) else $error("special kept");
  property p_untag;
    tag_done && $past(tag_pkt_type) == `PKT_UNTAGGED |->
      !tag_strip_vlan && !tag_rewrite_vlan && !tag_strip_special;
  endproperty
  a_untag: assert property (p_untag) else $error("untagged edited");
  property p_ins;
    tag_done && tag_insert_vlan |-> $past(tag_pkt_type) == `PKT_UNTAGGED;
  endproperty
  a_ins: assert property (p_ins) else $error("insert on tagged");
  property p_excl;
    tag_done && tag_strip_vlan |-> !tag_insert_vlan && !tag_rewrite_vlan;
  endproperty
  a_excl: assert property (p_excl) else $error("strip and edit");
  property p_fcs;
    tag_done |-> fcs_recompute == (tag_strip_vlan || tag_strip_special ||
      tag_insert_vlan || tag_rewrite_vlan || tag_add_special);
  endproperty
  a_fcs: assert property (p_fcs) else $error("fcs flag");
endmodule // egress_shaper_tagger_checker

bind egress_shaper_tagger egress_shaper_tagger_checker u_chk (.*);

// ==== dv/tx_mac_model.sv ====
// Scheduler and transmit MAC model that picks the top eligible queue.
`timescale 1ns/1ps
module tx_mac_model (
  input wire aclk,
  input wire go,
  input wire [1:0] port,
  input wire [10:0] len,
  input wire [11:0] q_eligible,
  output reg sel_valid,
  output reg [1:0] sel_port,
  output reg [1:0] sel_queue,
  output reg [10:0] sel_len
);
  // ------------------------------------------------------------
  // Picking
  // ------------------------------------------------------------
  integer q;
  initial begin
    sel_valid = 1'b0;
    sel_port = 2'h0;
    sel_queue = 2'h0;
    sel_len = 11'h000;
  end
  // Idle payload keeps toggling so no stale value can pass for a pick.
  always @(posedge aclk) begin
    sel_valid <= 1'b0;
    sel_len <= ~sel_len;
    for (q = 0; q < 4; q = q + 1) begin
      if (go && q_eligible[port * 4 + q]) begin
        sel_valid <= 1'b1;
        sel_queue <= q[1:0];
        sel_port <= port;
        sel_len <= len;
      end
    end
  end
endmodule // tx_mac_model

// ==== dv/egress_shaper_tagger_tb.sv ====
// Self-checking bench for the egress shaper and tag editor.
`timescale 1ns/1ps
`include "egress_consts.vh"
module egress_shaper_tagger_tb;
  // ------------------------------------------------------------
  // Signals, design and partner
  // ------------------------------------------------------------
  logic aclk = 0, aresetn = 0, ce = 1, go = 0;
  logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_arvalid = 0;
  logic s_axi_bready = 1, s_axi_rready = 1;
  logic [31:0] s_axi_wdata = 0;
  logic [3:0] s_axi_wstrb = 4'hf;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid;
  wire s_axi_arready, s_axi_rvalid;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  logic [11:0] q_nonempty = 0, tag_rx_vid = 0;
  logic [2:0] port_10m = 0, tag_rx_prio = 0, tag_untag_bits = 0;
  wire [11:0] q_eligible, tag_out_vid, tag_special_vid;
  wire sel_valid, tag_done, tag_strip_vlan, tag_strip_special;
  wire tag_insert_vlan, tag_rewrite_vlan, tag_add_special, fcs_recompute;
  wire [1:0] sel_port, sel_queue;
  wire [10:0] sel_len;
  wire [2:0] tag_out_prio;
  logic tag_req = 0, drop_valid = 0, drop_by_rate = 0;
  logic [1:0] tag_pkt_type = 0, tag_ingress_port = 0, tag_egress_port = 0;
  logic [1:0] drop_src_port = 0, go_port = 0;
  logic [10:0] go_len = 0;
  int fail_count = 0, compares = 0;
  int pc[3], dflt[3], tot[3], rat[3];
  int i, p, s, n, len, v, sp, br, ex, seed;
  int tbl[6] = '{0, 3, 4, 9, 39, 40};
  egress_shaper_tagger dut (.*);
  tx_mac_model mac (.aclk(aclk), .go(go), .port(go_port), .len(go_len),
    .q_eligible(q_eligible), .sel_valid(sel_valid), .sel_port(sel_port),
    .sel_queue(sel_queue), .sel_len(sel_len));
  always #20 aclk = ~aclk;
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task test_done;
    $display("compares %0d mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task wr(input [7:0] a, input [31:0] d);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wready) s_axi_wvalid <= 0;
    end while (!s_axi_bvalid);
    chk("bresp", (a >= `OFF_TDROP_BASE) ? `RESP_SLVERR : `RESP_OKAY,
      s_axi_bresp);
  endtask
  task rd(input [7:0] a, input logic [31:0] e, input [1:0] r);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 0;
    end while (!s_axi_rvalid);
    chk("rdata", e, s_axi_rdata);
    chk("rresp", {30'h0, r}, {30'h0, s_axi_rresp});
  endtask
  task automatic tag(input int pt, input int ip, input int ep);
    int c, ub, sv, ins, rw, vid, pr;
    logic [2:0] u;
    logic [11:0] rv;
    logic [2:0] rp;
    c = pc[ep];
    u = $urandom;
    rv = $urandom;
    rp = $urandom;
    ub = u[ip];
    sv = 0;
    ins = 0;
    rw = 0;
    vid = (pt == 1) ? dflt[ip] & 'hfff : rv;
    pr = rp;
    if (c[1:0] == 1) sv = (pt == 1 || pt == 2);
    if (c[1:0] == 2 && pt == 0) begin
      ins = c[2] && !ub;
      vid = dflt[ip] & 'hfff;
      pr = dflt[ip] >> 12;
    end
    if (c[1:0] == 2 && pt == 1) begin
      sv = ub;
      rw = !ub;
      if (c[5]) pr = dflt[ip] >> 12;
    end
    if (c[1:0] == 2 && pt == 2) begin
      sv = ub;
      rw = !ub && c[3] && (c[4] || c[5]);
      if (c[4]) vid = dflt[ep] & 'hfff;
      if (c[5]) pr = dflt[ep] >> 12;
    end
    ex = {sv[0], pt == 3, ins[0], rw[0], c[1:0] == 3};
    tag_req <= 1;
    tag_pkt_type <= pt;
    tag_ingress_port <= ip;
    tag_egress_port <= ep;
    tag_rx_vid <= rv;
    tag_rx_prio <= rp;
    tag_untag_bits <= u;
    @(posedge aclk);
    tag_req <= 0;
    @(posedge aclk);
    chk("tag_flags", ex, {tag_strip_vlan, tag_strip_special,
      tag_insert_vlan, tag_rewrite_vlan, tag_add_special});
    if (ins || rw) chk("tag_vid_prio", {pr[2:0], vid[11:0]},
      {tag_out_prio, tag_out_vid});
    chk("tag_misc", {18'h0, ip[11:0], 1'b1, ex != 0},
      {18'h0, tag_special_vid, tag_done, fcs_recompute});
  endtask
  task pick(input [1:0] pt, input [10:0] ln, input [1:0] eq);
    go <= 1;
    go_port <= pt;
    go_len <= ln;
    @(posedge aclk);
    go <= 0;
    @(posedge aclk);
    chk("picked_queue", {29'h0, 1'b1, eq}, {29'h0, sel_valid, sel_queue});
  endtask
  initial begin
    #(40 * 40000);
    fail_count++;
    $display("watchdog expired");
    test_done;
  end
  initial begin
    seed = $urandom(70);
    repeat (2) @(posedge aclk);
    aresetn <= 1;
    @(posedge aclk);
    rd(`OFF_PORT_TYPE, 0, `RESP_OKAY);
    rd(`OFF_LIMIT_EN, 0, `RESP_OKAY);
    rd(`OFF_RATE_BASE, 0, `RESP_OKAY);
    rd(8'h1c, 0, `RESP_SLVERR);
    wr(`OFF_TDROP_BASE, 32'hffffffff);
    rd(`OFF_TDROP_BASE, 0, `RESP_OKAY);
    for (p = 0; p < 3; p++) begin
      rd(8'(`OFF_DFLT_BASE + 4 * p), 1, `RESP_OKAY);
      dflt[p] = $urandom & 'h7fff;
      wr(8'(`OFF_DFLT_BASE + 4 * p), dflt[p]);
      rd(8'(`OFF_DFLT_BASE + 4 * p), dflt[p], `RESP_OKAY);
    end
    $display("test registers done");
    for (s = 0; s < 4; s++) begin
      for (p = 0; p < 3; p++) pc[p] = ($urandom % 16) * 4 + s;
      wr(`OFF_PORT_TYPE, pc[2] * 65536 + pc[1] * 256 + pc[0]);
      rd(`OFF_PORT_TYPE, pc[2] * 65536 + pc[1] * 256 + pc[0], 0);
      for (i = 0; i < 12; i++) tag(i % 4, $urandom % 3, $urandom % 3);
    end
    $display("test tag_editor done");
    q_nonempty <= 12'h0f0;
    wr(`OFF_LIMIT_EN, 32'h080);
    wr(8'(`OFF_RATE_BASE + 28), 9);
    pick(1, 40, 2'h3);
    repeat (3) @(posedge aclk);
    pick(1, 8, 2'h2);
    q_nonempty <= 12'h010;
    wr(`OFF_LIMIT_EN, 32'h010);
    for (i = 0; i < 6; i++) begin
      s = tbl[i];
      len = 4 + $urandom % 37;
      port_10m <= (s >= 39) ? 3'h2 : 3'h0;
      wr(8'(`OFF_RATE_BASE + 16), s);
      repeat (2) @(posedge aclk);
      pick(1, len, 2'h0);
      n = 0;
      @(posedge aclk);
      while (!q_eligible[4] && n < 5000) begin
        @(posedge aclk);
        n++;
      end
      ex = (s > 39) ? 0 : len * ((s < 3) ? 4 : s + 1) / 2;
      chk("hold_cycles", ex, (n + 2 >= ex && n <= ex + 2) ? ex : n);
    end
    $display("test limiter done");
    for (i = 0; i < 40; i++) begin
      v = $urandom % 2;
      sp = $urandom % 4;
      br = $urandom % 2;
      drop_valid <= v;
      drop_src_port <= sp;
      drop_by_rate <= br;
      ce <= (i % 10 != 9);
      if (v && sp < 3 && i % 10 != 9) tot[sp]++;
      if (v && sp < 3 && br && i % 10 != 9) rat[sp]++;
      @(posedge aclk);
    end
    drop_valid <= 0;
    ce <= 1;
    @(posedge aclk);
    for (p = 0; p < 3; p++) begin
      rd(8'(`OFF_TDROP_BASE + 4 * p), tot[p], `RESP_OKAY);
      rd(8'(`OFF_RDROP_BASE + 4 * p), rat[p], `RESP_OKAY);
    end
    $display("test drop_counters done");
    test_done;
  end
endmodule // egress_shaper_tagger_tb
